//--- hdl/btd_map.vh
`ifndef BTD_MAP_VH
`define BTD_MAP_VH

// Instruction word fields: opcode, destination/source register, selector.
`define BTD_OP_MSB 15
`define BTD_OP_LSB 11
`define BTD_RD_MSB 10
`define BTD_RD_LSB 6
`define BTD_SEL_MSB 5

// Opcodes.
`define BTD_OP_FLAG_SET 5'h00
`define BTD_OP_FLAG_CLR 5'h01
`define BTD_OP_BIT_TO_T 5'h02
`define BTD_OP_T_TO_BIT 5'h03
`define BTD_OP_COPY 5'h04
`define BTD_OP_PAIR_COPY 5'h05
`define BTD_OP_IMM_LOAD 5'h06
`define BTD_OP_LOAD_IND 5'h07
`define BTD_OP_LOAD_DISP 5'h08
`define BTD_OP_LOAD_DIR 5'h09
`define BTD_OP_STORE_IND 5'h0A
`define BTD_OP_STORE_DISP 5'h0B
`define BTD_OP_STORE_DIR 5'h0C
`define BTD_OP_PM_READ 5'h0D
`define BTD_OP_PM_WRITE 5'h0E
`define BTD_OP_PORT_READ 5'h0F
`define BTD_OP_PORT_WRITE 5'h10
`define BTD_OP_STACK_SAVE 5'h11
`define BTD_OP_STACK_RESTORE 5'h12
`define BTD_OP_NOP 5'h13
`define BTD_OP_SLEEP 5'h14
`define BTD_OP_WD_RESTART 5'h15
`define BTD_OP_BREAK 5'h16

// Pointer access modes in selector bits 3:2; pointer choice in bits 1:0.
`define BTD_MODE_PLAIN 2'h0
`define BTD_MODE_POST_INC 2'h1
`define BTD_MODE_PRE_DEC 2'h2
`define BTD_PTR_BASE 5'h1A

// Status register bit positions.
`define BTD_FLAG_C 3'h0
`define BTD_FLAG_Z 3'h1
`define BTD_FLAG_N 3'h2
`define BTD_FLAG_V 3'h3
`define BTD_FLAG_S 3'h4
`define BTD_FLAG_H 3'h5
`define BTD_FLAG_T 3'h6
`define BTD_FLAG_I 3'h7

// Reset values and I/O mapping.
`define BTD_STATUS_REGISTER_RESET 8'h00
`define BTD_SP_RESET 16'h0FFF
`define BTD_IO_DATA_OFFSET 16'h0020

`endif

//--- hdl/btd_core.v
`include "btd_map.vh"

module btd_core (
    input wire sys_clk,
    input wire reset,
    input wire instrValid,
    input wire [15:0] instrWord,
    input wire [15:0] instrExt,
    output wire instrReady,
    output reg instrDone,
    output reg [7:0] statusRegister,
    output reg [15:0] stackPointer,
    input wire [4:0] regSelect,
    output reg [7:0] regValue,
    output reg [15:0] dmAddr,
    output reg [7:0] dmWrData,
    output reg dmWrite,
    output reg dmRead,
    input wire [7:0] dmRdData,
    output reg [15:0] pmAddr,
    output reg [15:0] pmWrData,
    output reg pmWrite,
    output reg pmRead,
    input wire [7:0] pmRdData,
    output reg sleepRequest,
    output reg watchdogRestart,
    output reg debugBreak,
    input wire debugResume
);

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_MEM = 3'b010;
    localparam [2:0] S_HALT = 3'b100;

    reg [2:0] state;
    reg [7:0] gpr [0:31];
    reg wbPend;
    reg wbFromPm;
    reg [4:0] wbIdx;
    integer i;

    wire [4:0] op = instrWord[`BTD_OP_MSB:`BTD_OP_LSB];
    wire [4:0] fd = instrWord[`BTD_RD_MSB:`BTD_RD_LSB];
    wire [5:0] sel = instrWord[`BTD_SEL_MSB:0];
    wire [2:0] bitIdx = sel[2:0];
    wire [1:0] mode = sel[3:2];
    wire [4:0] rr = sel[4:0];
    wire [4:0] pairD = {fd[4:1], 1'b0};
    wire [4:0] pairR = {rr[4:1], 1'b0};
    wire [4:0] ptrLo = `BTD_PTR_BASE + {2'b00, sel[1:0], 1'b0};
    wire [4:0] ptrHi = ptrLo + 5'h01;
    wire accept = instrValid && instrReady;

    assign instrReady = state[0];

    // A port read retires without a stall, so its byte is still in flight
    // when the next instruction reads operands; this bypass covers that gap.
    function [7:0] rdReg;
        input [4:0] idx;
        begin
            if (wbPend && wbIdx == idx) begin
                rdReg = wbFromPm ? pmRdData : dmRdData;
            end else begin
                rdReg = gpr[idx];
            end
        end
    endfunction

    wire [7:0] fdVal = rdReg(fd);
    wire [7:0] rrVal = rdReg(rr);
    wire [15:0] ptrVal = {rdReg(ptrHi), rdReg(ptrLo)};
    wire [15:0] ptrInc = ptrVal + 16'h0001;
    wire [15:0] ptrDec = ptrVal - 16'h0001;
    wire [15:0] zVal = {rdReg(5'h1F), rdReg(5'h1E)};
    wire [15:0] zInc = zVal + 16'h0001;
    wire [15:0] spInc = stackPointer + 16'h0001;
    wire [15:0] dispAddr = ptrVal + {10'h000, instrExt[5:0]};
    // Port numbers are six bits, so port access can never reach extended I/O.
    wire [15:0] portAddr = {10'h000, instrExt[5:0]} + `BTD_IO_DATA_OFFSET;
    reg [7:0] bldVal;

    always @* begin
        bldVal = fdVal;
        bldVal[bitIdx] = statusRegister[`BTD_FLAG_T];
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= S_IDLE;
            statusRegister <= `BTD_STATUS_REGISTER_RESET;
            stackPointer <= `BTD_SP_RESET;
            for (i = 0; i < 32; i = i + 1) begin
                gpr[i] <= 8'h00;
            end
            wbPend <= 1'b0;
            wbFromPm <= 1'b0;
            wbIdx <= 5'h00;
            instrDone <= 1'b0;
            regValue <= 8'h00;
            dmAddr <= 16'h0000;
            dmWrData <= 8'h00;
            dmWrite <= 1'b0;
            dmRead <= 1'b0;
            pmAddr <= 16'h0000;
            pmWrData <= 16'h0000;
            pmWrite <= 1'b0;
            pmRead <= 1'b0;
            sleepRequest <= 1'b0;
            watchdogRestart <= 1'b0;
            debugBreak <= 1'b0;
        end else begin
            dmWrite <= 1'b0;
            dmRead <= 1'b0;
            pmWrite <= 1'b0;
            pmRead <= 1'b0;
            sleepRequest <= 1'b0;
            watchdogRestart <= 1'b0;
            debugBreak <= 1'b0;
            instrDone <= state[1];
            regValue <= rdReg(regSelect);
            // Memory answers in the strobe cycle; the byte lands here. A newer
            // write to the same register below is later and wins.
            wbPend <= 1'b0;
            if (wbPend) begin
                gpr[wbIdx] <= wbFromPm ? pmRdData : dmRdData;
            end
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        instrDone <= 1'b1;
                        case (op)
                            `BTD_OP_FLAG_SET: begin
                                statusRegister[bitIdx] <= 1'b1;
                            end
                            `BTD_OP_FLAG_CLR: begin
                                statusRegister[bitIdx] <= 1'b0;
                            end
                            `BTD_OP_BIT_TO_T: begin
                                statusRegister[`BTD_FLAG_T] <= fdVal[bitIdx];
                            end
                            `BTD_OP_T_TO_BIT: begin
                                gpr[fd] <= bldVal;
                            end
                            `BTD_OP_COPY: begin
                                gpr[fd] <= rrVal;
                            end
                            `BTD_OP_PAIR_COPY: begin
                                gpr[pairD] <= rdReg(pairR);
                                gpr[pairD + 5'h01] <= rdReg(pairR + 5'h01);
                            end
                            `BTD_OP_IMM_LOAD: begin
                                gpr[fd] <= instrExt[7:0];
                            end
                            `BTD_OP_LOAD_IND, `BTD_OP_STORE_IND: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                // Pre-decrement addresses the new value,
                                // post-increment the old one.
                                dmAddr <= (mode == `BTD_MODE_PRE_DEC) ? ptrDec : ptrVal;
                                if (mode == `BTD_MODE_PRE_DEC) begin
                                    gpr[ptrLo] <= ptrDec[7:0];
                                    gpr[ptrHi] <= ptrDec[15:8];
                                end
                                if (mode == `BTD_MODE_POST_INC) begin
                                    gpr[ptrLo] <= ptrInc[7:0];
                                    gpr[ptrHi] <= ptrInc[15:8];
                                end
                                if (op == `BTD_OP_LOAD_IND) begin
                                    dmRead <= 1'b1;
                                    wbPend <= 1'b1;
                                    wbFromPm <= 1'b0;
                                    wbIdx <= fd;
                                end else begin
                                    dmWrite <= 1'b1;
                                    dmWrData <= fdVal;
                                end
                            end
                            `BTD_OP_LOAD_DISP: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= dispAddr;
                                dmRead <= 1'b1;
                                wbPend <= 1'b1;
                                wbFromPm <= 1'b0;
                                wbIdx <= fd;
                            end
                            `BTD_OP_STORE_DISP: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= dispAddr;
                                dmWrite <= 1'b1;
                                dmWrData <= fdVal;
                            end
                            `BTD_OP_LOAD_DIR: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= instrExt;
                                dmRead <= 1'b1;
                                wbPend <= 1'b1;
                                wbFromPm <= 1'b0;
                                wbIdx <= fd;
                            end
                            `BTD_OP_STORE_DIR: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= instrExt;
                                dmWrite <= 1'b1;
                                dmWrData <= fdVal;
                            end
                            `BTD_OP_PM_READ: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                pmAddr <= zVal;
                                pmRead <= 1'b1;
                                wbPend <= 1'b1;
                                wbFromPm <= 1'b1;
                                wbIdx <= sel[0] ? fd : 5'h00;
                                if (sel[1]) begin
                                    gpr[5'h1E] <= zInc[7:0];
                                    gpr[5'h1F] <= zInc[15:8];
                                end
                            end
                            `BTD_OP_PM_WRITE: begin
                                pmAddr <= zVal;
                                pmWrite <= 1'b1;
                                pmWrData <= {rdReg(5'h01), rdReg(5'h00)};
                            end
                            `BTD_OP_PORT_READ: begin
                                dmAddr <= portAddr;
                                dmRead <= 1'b1;
                                wbPend <= 1'b1;
                                wbFromPm <= 1'b0;
                                wbIdx <= fd;
                            end
                            `BTD_OP_PORT_WRITE: begin
                                dmAddr <= portAddr;
                                dmWrite <= 1'b1;
                                dmWrData <= fdVal;
                            end
                            `BTD_OP_STACK_SAVE: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= stackPointer;
                                dmWrite <= 1'b1;
                                dmWrData <= fdVal;
                                stackPointer <= stackPointer - 16'h0001;
                            end
                            `BTD_OP_STACK_RESTORE: begin
                                instrDone <= 1'b0;
                                state <= S_MEM;
                                dmAddr <= spInc;
                                dmRead <= 1'b1;
                                stackPointer <= spInc;
                                wbPend <= 1'b1;
                                wbFromPm <= 1'b0;
                                wbIdx <= fd;
                            end
                            `BTD_OP_SLEEP: begin
                                sleepRequest <= 1'b1;
                            end
                            `BTD_OP_WD_RESTART: begin
                                watchdogRestart <= 1'b1;
                            end
                            `BTD_OP_BREAK: begin
                                // The core holds until the debugger lets go.
                                instrDone <= 1'b0;
                                debugBreak <= 1'b1;
                                state <= S_HALT;
                            end
                            default: begin
                                instrDone <= 1'b1;
                            end
                        endcase
                    end
                end
                S_MEM: begin
                    state <= S_IDLE;
                end
                S_HALT: begin
                    if (debugResume) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // btd_core

//--- dv/btd_core_monitor.sv
`include "btd_map.vh"
module btd_core_monitor (
    input wire sys_clk,
    input wire reset,
    input wire instrValid,
    input wire [15:0] instrWord,
    input wire [15:0] instrExt,
    input wire instrReady,
    input wire instrDone,
    input wire [7:0] statusRegister,
    input wire [15:0] dmAddr,
    input wire dmWrite,
    input wire dmRead,
    input wire sleepRequest,
    input wire watchdogRestart,
    input wire debugBreak
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [4:0] op = instrWord[15:11];
    wire [2:0] idx = instrWord[2:0];
    wire [15:0] portAt = {10'h000, instrExt[5:0]} + 16'h0020;
    wire take = instrValid && instrReady;
    wire isLoad = op inside {`BTD_OP_LOAD_IND, `BTD_OP_LOAD_DISP, `BTD_OP_LOAD_DIR,
        `BTD_OP_STACK_RESTORE};
    wire isStore = op inside {`BTD_OP_STORE_IND, `BTD_OP_STORE_DISP, `BTD_OP_STORE_DIR,
        `BTD_OP_STACK_SAVE};
    // Single-cycle operations that must leave every status flag alone.
    wire quiet = op inside {`BTD_OP_COPY, `BTD_OP_PAIR_COPY, `BTD_OP_IMM_LOAD, `BTD_OP_PM_WRITE,
        `BTD_OP_PORT_READ, `BTD_OP_PORT_WRITE, `BTD_OP_NOP, `BTD_OP_SLEEP, `BTD_OP_WD_RESTART};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    one_cycle_a: assert property (take && (quiet || op < 5'h04) |=> instrDone)
        else $error("single-cycle operation did not retire after one cycle");
    two_cycle_a: assert property (take && (isLoad || isStore) |=>
        !instrReady && !instrDone ##1 instrDone)
        else $error("two-cycle operation did not retire after two cycles");
    load_strobe_a: assert property (take && isLoad |=> dmRead && !dmWrite)
        else $error("load did not strobe a data read");
    store_strobe_a: assert property (take && isStore |=> dmWrite && !dmRead)
        else $error("store did not strobe a data write");
    direct_addr_a: assert property (take && op inside {`BTD_OP_LOAD_DIR, `BTD_OP_STORE_DIR}
        |=> dmAddr == $past(instrExt))
        else $error("direct access went to the wrong address");
    port_addr_a: assert property (take && op inside {`BTD_OP_PORT_READ, `BTD_OP_PORT_WRITE}
        |=> dmAddr == $past(portAt) && dmAddr < 16'h0060)
        else $error("port access not mapped into data space plus offset");
    flag_set_a: assert property (take && op == `BTD_OP_FLAG_SET |=>
        statusRegister == ($past(statusRegister) | (8'h01 << $past(idx))))
        else $error("flag set touched the wrong bits");
    flag_clear_a: assert property (take && op == `BTD_OP_FLAG_CLR |=>
        statusRegister == ($past(statusRegister) & ~(8'h01 << $past(idx))))
        else $error("flag clear touched the wrong bits");
    flags_kept_a: assert property (take && quiet |=> $stable(statusRegister))
        else $error("flag-free operation changed the status flags");
    sleep_pulse_a: assert property (take && op == `BTD_OP_SLEEP |=>
        sleepRequest ##1 !sleepRequest)
        else $error("sleep request was not a one-cycle pulse");
    wdog_pulse_a: assert property (take && op == `BTD_OP_WD_RESTART |=>
        watchdogRestart ##1 !watchdogRestart)
        else $error("watchdog restart was not a one-cycle pulse");
    break_halt_a: assert property (take && op == `BTD_OP_BREAK |=> debugBreak && !instrReady)
        else $error("break did not raise a debug stop and halt");
    cover property (take && isLoad);
    cover property (take && isStore);
    cover property (take && op == `BTD_OP_BREAK);
    cover property (take && op == `BTD_OP_WD_RESTART);
endmodule // btd_core_monitor

bind btd_core btd_core_monitor u_mon (.sys_clk, .reset, .instrValid, .instrWord, .instrExt,
    .instrReady, .instrDone, .statusRegister, .dmAddr, .dmWrite, .dmRead, .sleepRequest,
    .watchdogRestart, .debugBreak);

//--- dv/btd_mem_model.sv
module btd_mem_model (
    input wire sys_clk,
    input wire [15:0] dmAddr,
    input wire [7:0] dmWrData,
    input wire dmWrite,
    input wire dmRead,
    output wire [7:0] dmRdData,
    input wire [15:0] pmAddr,
    input wire [15:0] pmWrData,
    input wire pmWrite,
    input wire pmRead,
    output wire [7:0] pmRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] dmem [0:4095];
    logic [7:0] pbyte [0:255];
    logic [15:0] pword [0:255];
    logic [7:0] lastDm = 8'h00;
    logic [7:0] lastPm = 8'h00;
    // An idle read bus toggles every cycle, so sampling outside the strobe cannot pass by luck.
    assign dmRdData = dmRead ? dmem[dmAddr[11:0]] : ~lastDm;
    assign pmRdData = pmRead ? pbyte[pmAddr[7:0]] : ~lastPm;
    always @(posedge sys_clk) begin
        lastDm <= dmRdData;
        lastPm <= pmRdData;
        if (dmWrite) begin
            dmem[dmAddr[11:0]] <= dmWrData;
        end
        if (pmWrite) begin
            pword[pmAddr[7:0]] <= pmWrData;
        end
    end
endmodule // btd_mem_model

//--- dv/bit_transfer_mcu_control_decode_test.sv
`include "btd_map.vh"
module bit_transfer_mcu_control_decode_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, instrValid, debugResume;
    logic [15:0] instrWord, instrExt;
    logic [4:0] regSelect;
    wire instrReady, instrDone, dmWrite, dmRead, pmWrite, pmRead;
    wire sleepRequest, watchdogRestart, debugBreak;
    wire [7:0] statusRegister, regValue, dmWrData, dmRdData, pmRdData;
    wire [15:0] stackPointer, dmAddr, pmAddr, pmWrData;
    int n_mismatch = 0;
    int checks_done = 0;
    btd_core u_dut (.sys_clk, .reset, .instrValid, .instrWord, .instrExt, .instrReady,
        .instrDone, .statusRegister, .stackPointer, .regSelect, .regValue, .dmAddr, .dmWrData,
        .dmWrite, .dmRead, .dmRdData, .pmAddr, .pmWrData, .pmWrite, .pmRead, .pmRdData,
        .sleepRequest, .watchdogRestart, .debugBreak, .debugResume);
    btd_mem_model u_mem (.sys_clk, .dmAddr, .dmWrData, .dmWrite, .dmRead, .dmRdData, .pmAddr,
        .pmWrData, .pmWrite, .pmRead, .pmRdData);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Issues one instruction and counts cycles until it retires, sampled at falling edges.
    task automatic exec(input logic [4:0] op, input logic [4:0] r, input logic [5:0] sel,
        input logic [15:0] ext, input int lat);
        int n;
        @(posedge sys_clk);
        instrWord <= {op, r, sel};
        instrExt <= ext;
        instrValid <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (instrDone !== 1'b1 && n < 8);
        chk("latency", 16'(lat), 16'(n));
    endtask
    task automatic rchk(input logic [4:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        regSelect <= idx;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("register", {8'h00, exp}, {8'h00, regValue});
    endtask
    task automatic loadImm(input logic [4:0] r, input logic [7:0] k);
        exec(`BTD_OP_IMM_LOAD, r, 6'h00, {8'h00, k}, 1);
    endtask
    task automatic setPtr(input logic [4:0] r, input logic [15:0] v);
        loadImm(r, v[7:0]);
        loadImm(r + 5'h01, v[15:8]);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // The full sequence needs well under a thousand cycles; a hang is cut off long after.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        instrExt = 16'h0000;
        regSelect = 5'h00;
        debugResume = 1'b0;
        u_mem.dmem[12'h100] = 8'h11;
        u_mem.dmem[12'h101] = 8'h22;
        u_mem.dmem[12'h200] = 8'h33;
        u_mem.dmem[12'h05F] = 8'h44;
        u_mem.pbyte[8'h10] = 8'h55;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk("status reset", 16'h0000, {8'h00, statusRegister});
        chk("stack reset", 16'h0FFF, stackPointer);
        for (int i = 0; i < 8; i++) begin
            exec(`BTD_OP_FLAG_SET, 5'h00, 6'(i), 16'h0000, 1);
            chk("flag set", 16'h0001 << i, {8'h00, statusRegister});
            exec(`BTD_OP_FLAG_CLR, 5'h00, 6'(i), 16'h0000, 1);
            chk("flag clear", 16'h0000, {8'h00, statusRegister});
        end
        $display("test flags done");
        loadImm(5'd16, 8'hA5);
        loadImm(5'd17, 8'h00);
        exec(`BTD_OP_BIT_TO_T, 5'd16, 6'h05, 16'h0000, 1);
        chk("t flag", 16'h0040, {8'h00, statusRegister});
        exec(`BTD_OP_T_TO_BIT, 5'd17, 6'h03, 16'h0000, 1);
        rchk(5'd17, 8'h08);
        chk("t kept", 16'h0040, {8'h00, statusRegister});
        exec(`BTD_OP_BIT_TO_T, 5'd16, 6'h01, 16'h0000, 1);
        chk("t cleared", 16'h0000, {8'h00, statusRegister});
        exec(`BTD_OP_COPY, 5'd18, 6'd16, 16'h0000, 1);
        rchk(5'd18, 8'hA5);
        exec(`BTD_OP_PAIR_COPY, 5'd20, 6'd16, 16'h0000, 1);
        rchk(5'd21, 8'h08);
        $display("test bits and copies done");
        setPtr(5'd26, 16'h0100);
        exec(`BTD_OP_LOAD_IND, 5'd1, {2'h0, `BTD_MODE_POST_INC, 2'h0}, 16'h0000, 2);
        rchk(5'd1, 8'h11);
        rchk(5'd26, 8'h01);
        exec(`BTD_OP_LOAD_IND, 5'd2, {2'h0, `BTD_MODE_PRE_DEC, 2'h0}, 16'h0000, 2);
        rchk(5'd2, 8'h11);
        exec(`BTD_OP_LOAD_IND, 5'd3, {2'h0, `BTD_MODE_PLAIN, 2'h0}, 16'h0000, 2);
        rchk(5'd3, 8'h11);
        rchk(5'd26, 8'h00);
        setPtr(5'd30, 16'h0100);
        exec(`BTD_OP_LOAD_DISP, 5'd4, 6'h02, 16'h0001, 2);
        rchk(5'd4, 8'h22);
        rchk(5'd30, 8'h00);
        exec(`BTD_OP_LOAD_DIR, 5'd5, 6'h00, 16'h0200, 2);
        rchk(5'd5, 8'h33);
        $display("test loads done");
        setPtr(5'd28, 16'h0300);
        exec(`BTD_OP_STORE_IND, 5'd16, {2'h0, `BTD_MODE_PRE_DEC, 2'h1}, 16'h0000, 2);
        chk("pre-dec store", 16'h00A5, {8'h00, u_mem.dmem[12'h2FF]});
        rchk(5'd28, 8'hFF);
        exec(`BTD_OP_STORE_IND, 5'd17, {2'h0, `BTD_MODE_POST_INC, 2'h1}, 16'h0000, 2);
        chk("post-inc store", 16'h0008, {8'h00, u_mem.dmem[12'h2FF]});
        rchk(5'd28, 8'h00);
        exec(`BTD_OP_STORE_IND, 5'd17, {2'h0, `BTD_MODE_PLAIN, 2'h1}, 16'h0000, 2);
        chk("plain store", 16'h0008, {8'h00, u_mem.dmem[12'h300]});
        exec(`BTD_OP_STORE_DISP, 5'd16, 6'h01, 16'h0005, 2);
        chk("disp store", 16'h00A5, {8'h00, u_mem.dmem[12'h305]});
        rchk(5'd28, 8'h00);
        exec(`BTD_OP_STORE_DIR, 5'd17, 6'h00, 16'h0400, 2);
        chk("direct store", 16'h0008, {8'h00, u_mem.dmem[12'h400]});
        exec(`BTD_OP_PORT_READ, 5'd6, 6'h00, 16'h003F, 1);
        rchk(5'd6, 8'h44);
        exec(`BTD_OP_PORT_WRITE, 5'd16, 6'h00, 16'h0001, 1);
        // A one-cycle store lands in memory one edge after it retires.
        @(negedge sys_clk);
        chk("port write", 16'h00A5, {8'h00, u_mem.dmem[12'h021]});
        $display("test stores and ports done");
        exec(`BTD_OP_STACK_SAVE, 5'd16, 6'h00, 16'h0000, 2);
        chk("stack byte", 16'h00A5, {8'h00, u_mem.dmem[12'hFFF]});
        chk("stack after save", 16'h0FFE, stackPointer);
        exec(`BTD_OP_STACK_RESTORE, 5'd7, 6'h00, 16'h0000, 2);
        rchk(5'd7, 8'hA5);
        chk("stack after restore", 16'h0FFF, stackPointer);
        setPtr(5'd30, 16'h0010);
        loadImm(5'd0, 8'h34);
        loadImm(5'd1, 8'h12);
        exec(`BTD_OP_PM_WRITE, 5'd0, 6'h00, 16'h0000, 1);
        @(negedge sys_clk);
        chk("program word", 16'h1234, u_mem.pword[8'h10]);
        exec(`BTD_OP_PM_READ, 5'd9, 6'h00, 16'h0000, 2);
        rchk(5'd0, 8'h55);
        exec(`BTD_OP_PM_READ, 5'd8, 6'h03, 16'h0000, 2);
        rchk(5'd8, 8'h55);
        rchk(5'd30, 8'h11);
        $display("test stack and program memory done");
        exec(`BTD_OP_NOP, 5'd0, 6'h00, 16'h0000, 1);
        exec(`BTD_OP_SLEEP, 5'd0, 6'h00, 16'h0000, 1);
        exec(`BTD_OP_WD_RESTART, 5'd0, 6'h00, 16'h0000, 1);
        @(posedge sys_clk);
        instrWord <= {`BTD_OP_BREAK, 11'h000};
        instrValid <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("halted", 16'h0000, {15'h0000, instrReady});
        @(posedge sys_clk);
        debugResume <= 1'b1;
        @(posedge sys_clk);
        debugResume <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("resumed", 16'h0001, {15'h0000, instrReady});
        $display("test control done");
        wrap_up();
    end
endmodule // bit_transfer_mcu_control_decode_test
